// ---- verilog/async_timer_pkg.sv ----
package async_timer_pkg;

  // ==========================================
  // Register indices on the plain port
  localparam logic [3:0] ADDR_CONTROL_A = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_B = 4'h1;
  localparam logic [3:0] ADDR_COUNTER   = 4'h2;
  localparam logic [3:0] ADDR_COMPARE_A = 4'h3;
  localparam logic [3:0] ADDR_COMPARE_B = 4'h4;
  localparam logic [3:0] ADDR_FLAG      = 4'h5;
  localparam logic [3:0] ADDR_MASK      = 4'h6;
  localparam logic [3:0] ADDR_ASYNC     = 4'h7;
  localparam logic [3:0] ADDR_POWER     = 4'h8;

  // ==========================================
  // Field positions
  localparam int FLAG_OVF   = 0;
  localparam int FLAG_CMPA  = 1;
  localparam int FLAG_CMPB  = 2;
  localparam int ASYNC_SEL  = 5;
  localparam int POWER_OFF  = 6;

  // ==========================================
  // Counter values and reset values
  localparam logic [7:0] BOTTOM_VALUE = 8'h00;
  localparam logic [7:0] MAX_VALUE    = 8'hFF;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [7:0] ONE_BYTE     = 8'h01;

  // Prescaler divisors for clock_select_field 2..7
  localparam logic [9:0] DIV_8    = 10'h007;
  localparam logic [9:0] DIV_32   = 10'h01F;
  localparam logic [9:0] DIV_64   = 10'h03F;
  localparam logic [9:0] DIV_128  = 10'h07F;
  localparam logic [9:0] DIV_256  = 10'h0FF;
  localparam logic [9:0] DIV_1024 = 10'h3FF;

  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b000,
    MODE_PC_MAX   = 3'b001,
    MODE_CTC      = 3'b010,
    MODE_FAST_MAX = 3'b011,
    MODE_RSV4     = 3'b100,
    MODE_PC_TOP   = 3'b101,
    MODE_RSV6     = 3'b110,
    MODE_FAST_TOP = 3'b111
  } wave_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cpu_req_t;

  typedef struct packed {
    logic [7:0]  control_a;
    logic [7:0]  control_b;
    logic [7:0]  counter;
    logic [7:0]  compare_a;
    logic [7:0]  compare_b;
    logic [7:0]  compare_a_buf;
    logic [7:0]  compare_b_buf;
    logic [2:0]  flags;
    logic [2:0]  mask;
    logic        async_sel;
    logic        power_off;
    logic        count_down;
    logic [9:0]  prescale;
    logic        osc_prev;
    logic        out_a;
    logic        out_b;
    logic [7:0]  rdata;
  } timer_state_t;

endpackage

// ---- verilog/async_timer.sv ----
// Overview of operation
// [RULE1] Counter and both compare values are eight-bit CPU-accessible registers.
// [RULE2] Every request shows as a flag and is gated by its own mask bit.
// [RULE3] Timer clock comes from I/O clock, or oscillator pin when async select set.
// [RULE4] Clock select zero stops the counter, flags and clears entirely.
// [RULE5] Each timer tick clears, increments or decrements per mode and direction.
// [RULE6] CPU reads/writes counter anytime; CPU write beats clear or count.
// [RULE7] Buffered compare values compared continuously; a match sets its flag.
// [RULE8] Bottom is 0x00, max is 0xFF, top is max or compare A by mode.
// [RULE9] Three-bit waveform mode: two low bits in control A, top bit in control B.
// [RULE10] Compare output mode never alters the counting sequence.
// [RULE11] Output mode picks polarity in PWM, set/clear/toggle otherwise.
// [RULE12] Normal mode counts up only, wrapping 0xFF to 0x00.
// [RULE13] Normal mode overflow flag set as counter becomes zero; logic never clears it.
// [RULE14] Normal mode accepts counter writes any time without side effects.
// [RULE15] Timer works only while the power-off bit is zero.
// [RULE16] Top and bottom indications assert at maximum value and zero; code raises top at compare A in MODE_CTC, MODE_PC_TOP and MODE_FAST_TOP.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module async_timer (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire async_timer_pkg::cpu_req_t cpu_req,
  output logic [7:0]                    rdata,
  input  wire logic                     osc_pin_1,
  output logic                          osc_pin_2,
  output logic                          compare_a_output,
  output logic                          compare_b_output,
  output logic                          top_ind,
  output logic                          bottom_ind,
  output logic                          irq
);

  async_timer_pkg::timer_state_t state_reg;
  async_timer_pkg::timer_state_t state_next;

  logic [2:0]                   wave_bits;
  async_timer_pkg::wave_mode_t  mode;
  logic [2:0]                   clock_select_field;
  logic [1:0]                   com_a;
  logic [1:0]                   com_b;
  logic                         pwm_mode;
  logic                         dual_slope;
  logic [7:0]                   top_value;
  logic                         src_tick;
  logic                         tick;
  logic                         match_a;
  logic                         match_b;
  logic                         at_top;
  logic                         at_bottom;
  logic                         wr_counter;

  // ==========================================
  // Decode
  assign wave_bits          = {state_reg.control_b[3], state_reg.control_a[1:0]};  // RULE9
  assign mode               = async_timer_pkg::wave_mode_t'(wave_bits);
  assign clock_select_field = state_reg.control_b[2:0];
  // Output modes only steer the waveform pins, never the counter
  assign com_a              = state_reg.control_a[7:6];  // RULE10
  assign com_b              = state_reg.control_a[5:4];
  assign pwm_mode           = (mode != async_timer_pkg::MODE_NORMAL) && (mode != async_timer_pkg::MODE_CTC);
  assign dual_slope         = (mode == async_timer_pkg::MODE_PC_MAX) || (mode == async_timer_pkg::MODE_PC_TOP);
  assign top_value          = (mode == async_timer_pkg::MODE_CTC || mode == async_timer_pkg::MODE_PC_TOP ||
                               mode == async_timer_pkg::MODE_FAST_TOP) ? state_reg.compare_a_buf
                                                                       : async_timer_pkg::MAX_VALUE;  // RULE8
  assign at_top             = (state_reg.counter == top_value);  // RULE16
  assign at_bottom          = (state_reg.counter == async_timer_pkg::BOTTOM_VALUE);  // RULE16
  assign match_a            = (state_reg.counter == state_reg.compare_a_buf);  // RULE7
  assign match_b            = (state_reg.counter == state_reg.compare_b_buf);  // RULE7
  assign wr_counter         = cpu_req.wr && (cpu_req.addr == async_timer_pkg::ADDR_COUNTER);

  // ==========================================
  // Clock source; oscillator pin sampled, rising edge is one tick
  always_comb begin
    if (state_reg.async_sel) begin
      src_tick = osc_pin_1 && !state_reg.osc_prev;  // RULE3
    end else begin
      case (clock_select_field)
        3'h1:    src_tick = 1'b1;
        3'h2:    src_tick = (state_reg.prescale[2:0] == async_timer_pkg::DIV_8[2:0]);
        3'h3:    src_tick = (state_reg.prescale[4:0] == async_timer_pkg::DIV_32[4:0]);
        3'h4:    src_tick = (state_reg.prescale[5:0] == async_timer_pkg::DIV_64[5:0]);
        3'h5:    src_tick = (state_reg.prescale[6:0] == async_timer_pkg::DIV_128[6:0]);
        3'h6:    src_tick = (state_reg.prescale[7:0] == async_timer_pkg::DIV_256[7:0]);
        3'h7:    src_tick = (state_reg.prescale == async_timer_pkg::DIV_1024);
        default: src_tick = 1'b0;
      endcase
    end
  end
  // Stopped select and power-off both kill the tick
  assign tick = src_tick && (clock_select_field != 3'h0) && !state_reg.power_off;  // RULE4 RULE15

  // ==========================================
  // Next state
  always_comb begin
    logic [2:0] set_flags;
    logic [7:0] cnt;
    logic       down;
    set_flags  = 3'b000;
    state_next = state_reg;
    cnt        = state_reg.counter;
    down       = state_reg.count_down;
    state_next.osc_prev = osc_pin_1;
    if (!state_reg.power_off) begin
      state_next.prescale = state_reg.prescale + 10'h001;
    end
    if (tick) begin
      // Compare values refresh on a tick at top in PWM modes, on every tick otherwise
      if (!pwm_mode || at_top) begin
        state_next.compare_a_buf = state_reg.compare_a;
        state_next.compare_b_buf = state_reg.compare_b;
      end
      set_flags[async_timer_pkg::FLAG_CMPA] = match_a;  // RULE7
      set_flags[async_timer_pkg::FLAG_CMPB] = match_b;
      case (mode)
        async_timer_pkg::MODE_NORMAL: begin
          cnt = state_reg.counter + async_timer_pkg::ONE_BYTE;  // RULE12
          set_flags[async_timer_pkg::FLAG_OVF] = (cnt == async_timer_pkg::BOTTOM_VALUE);  // RULE13
        end
        async_timer_pkg::MODE_CTC: begin
          cnt = match_a ? async_timer_pkg::BOTTOM_VALUE : state_reg.counter + async_timer_pkg::ONE_BYTE;
          set_flags[async_timer_pkg::FLAG_OVF] = at_bottom && !match_a &&
                                                 (state_reg.counter != async_timer_pkg::BOTTOM_VALUE) ? 1'b0 :
                                                 (state_reg.counter == async_timer_pkg::MAX_VALUE);
        end
        async_timer_pkg::MODE_PC_MAX, async_timer_pkg::MODE_PC_TOP: begin
          if (at_top) begin
            down = 1'b1;
          end else if (at_bottom) begin
            down = 1'b0;
          end
          cnt = down ? state_reg.counter - async_timer_pkg::ONE_BYTE
                     : state_reg.counter + async_timer_pkg::ONE_BYTE;  // RULE5
          set_flags[async_timer_pkg::FLAG_OVF] = at_bottom;
        end
        async_timer_pkg::MODE_FAST_MAX, async_timer_pkg::MODE_FAST_TOP: begin
          cnt = at_top ? async_timer_pkg::BOTTOM_VALUE : state_reg.counter + async_timer_pkg::ONE_BYTE;  // RULE5
          set_flags[async_timer_pkg::FLAG_OVF] = at_top;
        end
        default: begin
          cnt = state_reg.counter + async_timer_pkg::ONE_BYTE;
        end
      endcase
      // Waveform outputs
      if (pwm_mode) begin
        if (dual_slope) begin
          if (match_a) state_next.out_a = (com_a[0] ^ state_reg.count_down);  // RULE11
          if (match_b) state_next.out_b = (com_b[0] ^ state_reg.count_down);
        end else begin
          if (match_a) state_next.out_a = com_a[0];  // RULE11
          else if (at_top) state_next.out_a = !com_a[0];
          if (match_b) state_next.out_b = com_b[0];
          else if (at_top) state_next.out_b = !com_b[0];
        end
      end else begin
        if (match_a) begin
          case (com_a)
            2'h1:    state_next.out_a = !state_reg.out_a;  // RULE11
            2'h2:    state_next.out_a = 1'b0;
            2'h3:    state_next.out_a = 1'b1;
            default: state_next.out_a = state_reg.out_a;
          endcase
        end
        if (match_b) begin
          case (com_b)
            2'h1:    state_next.out_b = !state_reg.out_b;
            2'h2:    state_next.out_b = 1'b0;
            2'h3:    state_next.out_b = 1'b1;
            default: state_next.out_b = state_reg.out_b;
          endcase
        end
      end
    end
    state_next.count_down = down;
    // CPU write wins over clear and count, in any mode
    state_next.counter = wr_counter ? cpu_req.wdata : cnt;  // RULE6 RULE14
    // Register writes
    if (cpu_req.wr) begin
      case (cpu_req.addr)
        async_timer_pkg::ADDR_CONTROL_A: state_next.control_a = cpu_req.wdata;
        async_timer_pkg::ADDR_CONTROL_B: state_next.control_b = cpu_req.wdata;
        async_timer_pkg::ADDR_COMPARE_A: state_next.compare_a = cpu_req.wdata;  // RULE1
        async_timer_pkg::ADDR_COMPARE_B: state_next.compare_b = cpu_req.wdata;
        async_timer_pkg::ADDR_MASK:      state_next.mask      = cpu_req.wdata[2:0];
        async_timer_pkg::ADDR_ASYNC:     state_next.async_sel = cpu_req.wdata[async_timer_pkg::ASYNC_SEL];
        async_timer_pkg::ADDR_POWER:     state_next.power_off = cpu_req.wdata[async_timer_pkg::POWER_OFF];
        default: ;
      endcase
    end
    // Write one to clear; a same-cycle set wins
    if (cpu_req.wr && cpu_req.addr == async_timer_pkg::ADDR_FLAG) begin
      state_next.flags = (state_reg.flags & ~cpu_req.wdata[2:0]) | set_flags;  // RULE2
    end else begin
      state_next.flags = state_reg.flags | set_flags;  // RULE13
    end
    // Read data, one cycle later
    state_next.rdata = 8'h00;
    if (cpu_req.rd) begin
      case (cpu_req.addr)
        async_timer_pkg::ADDR_CONTROL_A: state_next.rdata = state_reg.control_a;
        async_timer_pkg::ADDR_CONTROL_B: state_next.rdata = state_reg.control_b;
        async_timer_pkg::ADDR_COUNTER:   state_next.rdata = state_reg.counter;  // RULE6
        async_timer_pkg::ADDR_COMPARE_A: state_next.rdata = state_reg.compare_a;
        async_timer_pkg::ADDR_COMPARE_B: state_next.rdata = state_reg.compare_b;
        async_timer_pkg::ADDR_FLAG:      state_next.rdata = {5'h00, state_reg.flags};
        async_timer_pkg::ADDR_MASK:      state_next.rdata = {5'h00, state_reg.mask};
        async_timer_pkg::ADDR_ASYNC:     state_next.rdata = {2'h0, state_reg.async_sel, 5'h00};
        async_timer_pkg::ADDR_POWER:     state_next.rdata = {1'b0, state_reg.power_off, 6'h00};
        default:                         state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // Outputs
  assign rdata            = state_reg.rdata;
  assign osc_pin_2        = !osc_pin_1;
  assign compare_a_output = state_reg.out_a;
  assign compare_b_output = state_reg.out_b;
  assign top_ind          = at_top;
  assign bottom_ind       = at_bottom;
  assign irq              = |(state_reg.flags & state_reg.mask);  // RULE2

  // ==========================================
  // Assertions
  property p_irq_gate;
    @(posedge clk) disable iff (reset)
      (cpu_req.wr && cpu_req.addr == async_timer_pkg::ADDR_FLAG && !tick &&
       (state_reg.flags & ~cpu_req.wdata[2:0]) == 3'h0) |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq left high after clearing flags");  // RULE2

  property p_stopped;
    @(posedge clk) disable iff (reset)
      (clock_select_field == 3'h0 && !wr_counter) |=> $stable(state_reg.counter);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");  // RULE4

  property p_power_off;
    @(posedge clk) disable iff (reset) (state_reg.power_off && !wr_counter) |=> $stable(state_reg.counter);
  endproperty
  a_power_off: assert property (p_power_off) else $error("counter moved while powered off");  // RULE15

  property p_cpu_write;
    @(posedge clk) disable iff (reset) wr_counter |=> state_reg.counter == $past(cpu_req.wdata);
  endproperty
  a_cpu_write: assert property (p_cpu_write) else $error("counter write lost");  // RULE6

  property p_normal_inc;
    @(posedge clk) disable iff (reset)
      (tick && mode == async_timer_pkg::MODE_NORMAL && !wr_counter)
        |=> state_reg.counter == $past(state_reg.counter) + 8'h01;
  endproperty
  a_normal_inc: assert property (p_normal_inc) else $error("normal mode did not increment");  // RULE12

  property p_overflow;
    @(posedge clk) disable iff (reset)
      (tick && mode == async_timer_pkg::MODE_NORMAL && state_reg.counter == 8'hFF) |=> state_reg.flags[0];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag not set");  // RULE13

  property p_match_a;
    @(posedge clk) disable iff (reset) (tick && match_a) |=> state_reg.flags[1];
  endproperty
  a_match_a: assert property (p_match_a) else $error("compare A flag not set");  // RULE7

  property p_read;
    @(posedge clk) disable iff (reset)
      (cpu_req.rd && cpu_req.addr == async_timer_pkg::ADDR_COMPARE_B) |=> rdata == $past(state_reg.compare_b);
  endproperty
  a_read: assert property (p_read) else $error("compare B readback wrong");  // RULE1

  property p_bottom;
    @(posedge clk) disable iff (reset) $rose(bottom_ind) |-> ($past(tick) || $past(wr_counter));
  endproperty
  a_bottom: assert property (p_bottom) else $error("bottom indication rose without a count or write");  // RULE16

  property p_match_b;
    @(posedge clk) disable iff (reset)
      (tick && match_b) |=> state_reg.flags[async_timer_pkg::FLAG_CMPB];
  endproperty
  a_match_b: assert property (p_match_b) else $error("compare B flag not set");  // RULE7

  property p_buffered;
    @(posedge clk) disable iff (reset)
      (pwm_mode && !(tick && at_top)) |=> $stable(state_reg.compare_a_buf);
  endproperty
  a_buffered: assert property (p_buffered) else $error("compare buffer loaded away from top");  // RULE7

  property p_stopped_flags;
    @(posedge clk) disable iff (reset)
      (clock_select_field == 3'h0 && !cpu_req.wr) |=> $stable(state_reg.flags);
  endproperty
  a_stopped_flags: assert property (p_stopped_flags) else $error("flags moved while stopped");  // RULE4

  property p_pc_turn;
    @(posedge clk) disable iff (reset)
      (tick && dual_slope && at_top && !wr_counter)
        |=> state_reg.count_down && (state_reg.counter == $past(state_reg.counter) - 8'h01);
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("dual slope did not turn at top");  // RULE5

  property p_fast_wrap;
    @(posedge clk) disable iff (reset)
      (tick && at_top && !wr_counter &&
       (mode == async_timer_pkg::MODE_FAST_MAX || mode == async_timer_pkg::MODE_FAST_TOP))
        |=> state_reg.counter == async_timer_pkg::BOTTOM_VALUE && state_reg.flags[async_timer_pkg::FLAG_OVF];
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("single slope did not wrap at top");  // RULE5

  property p_ctc_clear;
    @(posedge clk) disable iff (reset)
      (tick && mode == async_timer_pkg::MODE_CTC && match_a && !wr_counter)
        |=> state_reg.counter == async_timer_pkg::BOTTOM_VALUE;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("counter not cleared on compare A");  // RULE5

  property p_top_max;
    @(posedge clk) disable iff (reset)
      (mode == async_timer_pkg::MODE_NORMAL || mode == async_timer_pkg::MODE_PC_MAX ||
       mode == async_timer_pkg::MODE_FAST_MAX) |-> top_ind == (state_reg.counter == async_timer_pkg::MAX_VALUE);
  endproperty
  a_top_max: assert property (p_top_max) else $error("top indication not at max");  // RULE8

  property p_top_cmp;
    @(posedge clk) disable iff (reset)
      (mode == async_timer_pkg::MODE_CTC || mode == async_timer_pkg::MODE_PC_TOP ||
       mode == async_timer_pkg::MODE_FAST_TOP) |-> top_ind == (state_reg.counter == state_reg.compare_a_buf);
  endproperty
  a_top_cmp: assert property (p_top_cmp) else $error("top indication not at compare A");  // RULE8

  property p_async_src;
    @(posedge clk) disable iff (reset)
      (state_reg.async_sel && !(osc_pin_1 && !state_reg.osc_prev)) |-> !tick;
  endproperty
  a_async_src: assert property (p_async_src) else $error("tick without oscillator edge");  // RULE3

  property p_sync_src;
    @(posedge clk) disable iff (reset)
      (!state_reg.async_sel && clock_select_field == 3'h1 && !state_reg.power_off) |-> tick;
  endproperty
  a_sync_src: assert property (p_sync_src) else $error("I/O clock tick missing");  // RULE3

  property p_ovf_hold;
    @(posedge clk) disable iff (reset)
      (state_reg.flags[async_timer_pkg::FLAG_OVF] && !(cpu_req.wr && cpu_req.addr == async_timer_pkg::ADDR_FLAG))
        |=> state_reg.flags[async_timer_pkg::FLAG_OVF];
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag cleared by counting");  // RULE13

  property p_toggle;
    @(posedge clk) disable iff (reset)
      (tick && !pwm_mode && match_a && com_a == 2'h1) |=> compare_a_output != $past(compare_a_output);
  endproperty
  a_toggle: assert property (p_toggle) else $error("compare A output did not toggle");  // RULE11

  property p_power_tick;
    @(posedge clk) disable iff (reset)
      state_reg.power_off |-> !tick;
  endproperty
  a_power_tick: assert property (p_power_tick) else $error("tick while powered off");  // RULE15

  property p_rdata_idle;
    @(posedge clk) disable iff (reset) !cpu_req.rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");  // RULE1

  // ==========================================
  // Cover points
  // Each marks a path the bench must reach, not just allow
  c_overflow:  cover property (@(posedge clk) disable iff (reset) $rose(state_reg.flags[0]));
  c_irq:       cover property (@(posedge clk) disable iff (reset) $rose(irq));
  c_down:      cover property (@(posedge clk) disable iff (reset) $rose(state_reg.count_down));
  c_fast_wrap: cover property (@(posedge clk) disable iff (reset)
                               tick && at_top && mode == async_timer_pkg::MODE_FAST_TOP);
  c_ctc_clear: cover property (@(posedge clk) disable iff (reset)
                               tick && match_a && mode == async_timer_pkg::MODE_CTC);

endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic                      clk;
  logic                      reset;
  async_timer_pkg::cpu_req_t cpu_req;
  logic [7:0]                rdata;
  logic                      osc_pin_1;
  logic                      osc_pin_2;
  logic                      compare_a_output;
  logic                      compare_b_output;
  logic                      top_ind;
  logic                      bottom_ind;
  logic                      irq;
  int                        err_total;
  int                        samples_checked;
  logic [7:0]                first_val;
  logic [7:0]                rd_val;

  async_timer DUT (
    .clk              (clk),
    .reset            (reset),
    .cpu_req          (cpu_req),
    .rdata            (rdata),
    .osc_pin_1        (osc_pin_1),
    .osc_pin_2        (osc_pin_2),
    .compare_a_output (compare_a_output),
    .compare_b_output (compare_b_output),
    .top_ind          (top_ind),
    .bottom_ind       (bottom_ind),
    .irq              (irq)
  );

  // ==========================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is well under ten thousand cycles
  initial begin
    #500000;
    err_total = err_total + 1;
    results();
  end

  // ==========================================
  // Access tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] expected);
    samples_checked = samples_checked + 1;
    if (seen !== expected) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clk);
    cpu_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    cpu_req.wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [3:0] addr, output logic [7:0] data);
    @(posedge clk);
    cpu_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    cpu_req.rd <= 1'b0;
    #1;
    data = rdata;
  endtask

  task automatic rd_chk(input logic [3:0] addr, input logic [7:0] expected);
    logic [7:0] v;
    rd(addr, v);
    chk(v, expected);
  endtask

  // One oscillator tick, long enough for the osc_prev edge detect
  task automatic osc_tick();
    @(posedge clk);
    osc_pin_1 <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, osc_pin_2}, 8'h00);
    @(posedge clk);
    osc_pin_1 <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // Test sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    reset = 1'b1;
    osc_pin_1 = 1'b0;
    cpu_req = '{addr: 4'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({6'h00, bottom_ind, top_ind}, 8'h02);
    chk({7'h00, irq}, 8'h00);
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'h00);
    rd_chk(async_timer_pkg::ADDR_FLAG, 8'h00);
    rd_chk(4'h9, 8'h00);
    // Oscillator path, stopped clock first
    wr(async_timer_pkg::ADDR_ASYNC, 8'h20);
    wr(async_timer_pkg::ADDR_MASK, 8'h07);
    wr(async_timer_pkg::ADDR_COMPARE_A, 8'h02);
    wr(async_timer_pkg::ADDR_COMPARE_B, 8'h03);
    rd_chk(async_timer_pkg::ADDR_COMPARE_A, 8'h02);
    rd_chk(async_timer_pkg::ADDR_COMPARE_B, 8'h03);
    wr(async_timer_pkg::ADDR_COUNTER, 8'hFE);
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'hFE);
    osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'hFE);
    rd_chk(async_timer_pkg::ADDR_FLAG, 8'h00);
    // Toggle output mode set, must not change counting
    wr(async_timer_pkg::ADDR_CONTROL_A, 8'h50);
    wr(async_timer_pkg::ADDR_CONTROL_B, 8'h01);
    osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'hFF);
    chk({7'h00, top_ind}, 8'h01);
    rd_chk(async_timer_pkg::ADDR_FLAG, 8'h00);
    osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'h00);
    chk({7'h00, bottom_ind}, 8'h01);
    rd_chk(async_timer_pkg::ADDR_FLAG, 8'h01);
    chk({7'h00, irq}, 8'h01);
    repeat (4) osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'h04);
    rd_chk(async_timer_pkg::ADDR_FLAG, 8'h07);
    chk({6'h00, compare_b_output, compare_a_output}, 8'h03);
    // Masking and write-one-to-clear
    wr(async_timer_pkg::ADDR_MASK, 8'h01);
    wr(async_timer_pkg::ADDR_FLAG, 8'h01);
    rd_chk(async_timer_pkg::ADDR_FLAG, 8'h06);
    chk({7'h00, irq}, 8'h00);
    wr(async_timer_pkg::ADDR_MASK, 8'h04);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr(async_timer_pkg::ADDR_FLAG, 8'h06);
    rd_chk(async_timer_pkg::ADDR_FLAG, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // Power-off freezes the counter
    wr(async_timer_pkg::ADDR_POWER, 8'h40);
    osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'h04);
    wr(async_timer_pkg::ADDR_POWER, 8'h00);
    // Dual-slope mode turns round at the fixed top
    wr(async_timer_pkg::ADDR_CONTROL_A, 8'h01);
    wr(async_timer_pkg::ADDR_COUNTER, 8'hFE);
    osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'hFF);
    osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'hFE);
    // I/O clock: spacing of two reads gives the tick count
    wr(async_timer_pkg::ADDR_CONTROL_A, 8'h00);
    wr(async_timer_pkg::ADDR_ASYNC, 8'h00);
    wr(async_timer_pkg::ADDR_COUNTER, 8'h00);
    for (int sel = 1; sel < 8; sel++) begin
      int div;
      div = (sel == 1) ? 1 : (sel == 2) ? 8 : (sel == 3) ? 32 : (sel == 4) ? 64 :
            (sel == 5) ? 128 : (sel == 6) ? 256 : 1024;
      wr(async_timer_pkg::ADDR_CONTROL_B, {5'h00, 3'(sel)});
      rd(async_timer_pkg::ADDR_COUNTER, first_val);
      repeat (4 * div - 2) @(posedge clk);
      rd(async_timer_pkg::ADDR_COUNTER, rd_val);
      chk(rd_val - first_val, 8'h04);
    end
    // CPU write wins over a running count
    wr(async_timer_pkg::ADDR_CONTROL_B, 8'h01);
    wr(async_timer_pkg::ADDR_COUNTER, 8'h80);
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'h81);
    // Single slope with top from compare A, top mode bit in control B
    wr(async_timer_pkg::ADDR_ASYNC, 8'h20);
    wr(async_timer_pkg::ADDR_CONTROL_A, 8'h03);
    wr(async_timer_pkg::ADDR_CONTROL_B, 8'h09);
    wr(async_timer_pkg::ADDR_COUNTER, 8'h01);
    osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'h02);
    chk({7'h00, top_ind}, 8'h01);
    osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'h00);
    // Clear on compare A match
    wr(async_timer_pkg::ADDR_CONTROL_A, 8'h02);
    wr(async_timer_pkg::ADDR_CONTROL_B, 8'h01);
    repeat (2) osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'h02);
    osc_tick();
    rd_chk(async_timer_pkg::ADDR_COUNTER, 8'h00);
    results();
  end
endmodule
